/* core/err_bank_pkg.sv */
package err_bank_pkg;
  // ----------------------------------------
  // status word layout
  // ----------------------------------------
  localparam int VALID_BIT = 63;
  localparam int OVERFLOW_BIT = 62;
  localparam int UNCORR_BIT = 61;
  localparam int ENABLE_BIT = 60;
  localparam int MISC_VALID_FLAG_BIT = 59;
  localparam int ADDR_VALID_FLAG_BIT = 58;
  localparam int PCC_BIT = 57;
  localparam int SIGNALED_BIT = 56;
  localparam int ACTREQ_BIT = 55;
  localparam int CODE_MSB = 15;
  localparam int CAP_SER_BIT = 24;
  localparam logic [63:0] STATUS_RESET = 64'h0;

  // ----------------------------------------
  // register offsets (word index)
  // ----------------------------------------
  localparam logic [3:0] OFF_STATUS_LO = 4'h0;
  localparam logic [3:0] OFF_STATUS_HI = 4'h1;
  localparam logic [3:0] OFF_MISC_LO = 4'h2;
  localparam logic [3:0] OFF_MISC_HI = 4'h3;
  localparam logic [3:0] OFF_ADDR_LO = 4'h4;
  localparam logic [3:0] OFF_ADDR_HI = 4'h5;
  localparam logic [3:0] OFF_CAP = 4'h6;

  typedef enum logic [2:0] {
    ERR_CORRECTED,
    ERR_NO_ACTION,
    ERR_OPT_ACTION,
    ERR_REQ_ACTION,
    ERR_FATAL
  } err_class_t;
endpackage

/* core/err_report_if.sv */
`timescale 1ns/10ps
interface err_report_if;
  logic valid;
  err_bank_pkg::err_class_t err_class;
  logic [15:0] code;
  logic misc_ok;
  logic addr_ok;
  logic [63:0] misc;
  logic [63:0] addr;
  modport src(output valid, err_class, code, misc_ok, addr_ok, misc, addr);
  modport dst(input valid, err_class, code, misc_ok, addr_ok, misc, addr);
endinterface

/* core/err_classifier.sv */
`timescale 1ns/10ps
module err_classifier (
  input wire logic ser_cap_in,
  input wire err_bank_pkg::err_class_t class_in,
  output logic uncorr_out,
  output logic pcc_out,
  output logic sig_out,
  output logic ar_out,
  output logic recov_out,
  output logic mce_out
);
  // ----------------------------------------
  // flag encoding per class
  // ----------------------------------------
  always_comb begin
    uncorr_out = 1'b0;
    pcc_out = 1'b0;
    sig_out = 1'b0;
    ar_out = 1'b0;
    recov_out = 1'b0;
    case (class_in)
      // [RQ9] no action class
      err_bank_pkg::ERR_NO_ACTION: begin
        uncorr_out = 1'b1;
        recov_out = 1'b1;
      end
      // [RQ10] optional action class
      err_bank_pkg::ERR_OPT_ACTION: begin
        uncorr_out = 1'b1;
        sig_out = 1'b1;
        recov_out = 1'b1;
      end
      // [RQ11] required action class
      err_bank_pkg::ERR_REQ_ACTION: begin
        uncorr_out = 1'b1;
        sig_out = 1'b1;
        ar_out = 1'b1;
        recov_out = 1'b1;
      end
      err_bank_pkg::ERR_FATAL: begin
        uncorr_out = 1'b1;
        pcc_out = 1'b1;
      end
      default: begin
        uncorr_out = 1'b0;
      end
    endcase
    // without recovery support the recoverable classes fall back to plain fatal
    if (!ser_cap_in && recov_out) begin
      pcc_out = 1'b1;
      recov_out = 1'b0;
    end
    // [RQ8] flags only with capability
    if (!ser_cap_in) begin
      sig_out = 1'b0;
      ar_out = 1'b0;
    end
    // [RQ3] exception versus corrected path
    mce_out = pcc_out | sig_out;
  end
endmodule

/* core/err_bank.sv */
`timescale 1ns/10ps
// How it works
// [RQ1] capability bit 24 reads one when recovery support is built in.
// [RQ2] recoverable error logs valid, uncorrected set and context corrupt clear.
// [RQ3] recoverable errors go to corrected interrupt or exception by class.
// [RQ4] misc and address valid only when those registers hold data.
// [RQ5] signaled bit 56 set when an exception is raised; the code sets it only for the optional and required action classes.
// [RQ6] action required bit 55 set for the required action class.
// [RQ7] hardware never clears signaled or action required; software or reset does.
// [RQ8] signaled and action required only set with recovery support.
// [RQ9] no action class: uncorrected only, reported as corrected, no exception; the code also sets enable bit 60 for it.
// [RQ10] optional class: uncorrected, signaled, enable set; raises exception.
// [RQ11] required class: uncorrected, signaled, enable, action required set.
// [RQ12] uncorrected logs set valid and enable; empty bank leaves overflow clear.
// [RQ13] recoverable replaces corrected; corrected never replaces recoverable.
// [RQ14] fatal overwrites recoverable; merged result has context corrupt set.
// [RQ15] a second recoverable error keeps the first one's information.
// [RQ16] corrected error after recoverable does not replace it.
// [RQ17] any error into a valid bank sets overflow.
// [RQ18] second error never clears signaled or action required.
// [RQ19] merged recoverable errors OR their signaled and action required.
// [RQ20] software writes zero to status to empty the bank.
module err_bank #(
  parameter bit SER_SUPPORTED = 1'b1,
  parameter logic [7:0] BANK_COUNT = 8'h01
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic err_valid_in,
  input wire err_bank_pkg::err_class_t err_class_in,
  input wire logic [15:0] err_code_in,
  input wire logic misc_ok_in,
  input wire logic addr_ok_in,
  input wire logic [63:0] misc_data_in,
  input wire logic [63:0] addr_data_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic mce_out,
  output logic cmc_out
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [63:0] status_reg;
  logic [63:0] status_next;
  logic [63:0] misc_reg;
  logic [63:0] addr_reg;
  logic [31:0] rdata_reg;
  logic mce_reg;
  logic cmc_reg;
  logic take_new;
  logic [63:0] cap_word;

  err_report_if rpt ();

  assign rpt.valid = err_valid_in;
  assign rpt.err_class = err_class_in;
  assign rpt.code = err_code_in;
  assign rpt.misc_ok = misc_ok_in;
  assign rpt.addr_ok = addr_ok_in;
  assign rpt.misc = misc_data_in;
  assign rpt.addr = addr_data_in;

  logic n_uc;
  logic n_pcc;
  logic n_sig;
  logic n_ar;
  logic n_recov;
  logic n_mce;

  err_classifier u_cls (
    .ser_cap_in(SER_SUPPORTED),
    .class_in(rpt.err_class),
    .uncorr_out(n_uc),
    .pcc_out(n_pcc),
    .sig_out(n_sig),
    .ar_out(n_ar),
    .recov_out(n_recov),
    .mce_out(n_mce)
  );

  // ----------------------------------------
  // capability word
  // ----------------------------------------
  // [RQ1] recovery capability bit
  always_comb begin
    cap_word = 64'h0;
    cap_word[7:0] = BANK_COUNT;
    cap_word[err_bank_pkg::CAP_SER_BIT] = SER_SUPPORTED;
  end

  // ----------------------------------------
  // overwrite decision and merge
  // ----------------------------------------
  logic old_valid;
  logic old_uc;
  logic old_pcc;
  logic [63:0] fresh;

  assign old_valid = status_reg[err_bank_pkg::VALID_BIT];
  assign old_uc = status_reg[err_bank_pkg::UNCORR_BIT];
  assign old_pcc = status_reg[err_bank_pkg::PCC_BIT];

  always_comb begin
    fresh = 64'h0;
    // [RQ12] valid and enable on uncorrected logs
    fresh[err_bank_pkg::VALID_BIT] = 1'b1;
    fresh[err_bank_pkg::ENABLE_BIT] = n_uc;
    // [RQ2] recoverable encoding
    fresh[err_bank_pkg::UNCORR_BIT] = n_uc;
    fresh[err_bank_pkg::PCC_BIT] = n_pcc;
    // [RQ4] companion data valid flags
    fresh[err_bank_pkg::MISC_VALID_FLAG_BIT] = rpt.misc_ok;
    fresh[err_bank_pkg::ADDR_VALID_FLAG_BIT] = rpt.addr_ok;
    // [RQ5] signaled for optional and required action classes only; fatal raises an exception with it clear
    fresh[err_bank_pkg::SIGNALED_BIT] = n_sig;
    // [RQ6] action required bit
    fresh[err_bank_pkg::ACTREQ_BIT] = n_ar;
    fresh[err_bank_pkg::CODE_MSB:0] = rpt.code;
  end

  always_comb begin
    take_new = 1'b0;
    if (!old_valid) begin
      take_new = 1'b1;
    end else if (n_pcc && !old_pcc) begin
      // [RQ14] fatal overwrites recoverable
      take_new = 1'b1;
    end else if (n_uc && !old_uc) begin
      // [RQ13] recoverable replaces corrected
      take_new = 1'b1;
    end else begin
      // [RQ15] keep first recoverable error
      // [RQ16] corrected never replaces recoverable
      take_new = 1'b0;
    end
  end

  always_comb begin
    status_next = status_reg;
    if (rpt.valid) begin
      if (take_new) begin
        status_next = fresh;
      end
      // [RQ17] overflow on occupied bank
      status_next[err_bank_pkg::OVERFLOW_BIT] = old_valid;
      // [RQ18] sticky flags survive a second error
      // [RQ19] merge by OR of signaled and action required
      status_next[err_bank_pkg::SIGNALED_BIT] =
        status_reg[err_bank_pkg::SIGNALED_BIT] | n_sig;
      status_next[err_bank_pkg::ACTREQ_BIT] =
        status_reg[err_bank_pkg::ACTREQ_BIT] | n_ar;
      // [RQ19] merged recoverable stays uncorrected
      status_next[err_bank_pkg::UNCORR_BIT] = old_uc | n_uc;
      // [RQ14] merge with fatal keeps context corrupt
      status_next[err_bank_pkg::PCC_BIT] = old_pcc | n_pcc;
    end
  end

  // ----------------------------------------
  // status register
  // ----------------------------------------
  // software writes land after hardware merge so a write of zero empties the bank;
  // a same-cycle error is then dropped, which software sees as a lost log
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_reg <= err_bank_pkg::STATUS_RESET;
    end else if (reg_wr_in && reg_addr_in == err_bank_pkg::OFF_STATUS_LO) begin
      // [RQ7] low word write leaves the sticky flags, which only a high word write clears
      status_reg[31:0] <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == err_bank_pkg::OFF_STATUS_HI) begin
      // [RQ20] software write empties bank
      status_reg[63:32] <= reg_wdata_in;
    end else begin
      // [RQ7] hardware path only ORs sticky flags
      status_reg <= status_next;
    end
  end

  // ----------------------------------------
  // companion registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      misc_reg <= 64'h0;
      addr_reg <= 64'h0;
    end else if (rpt.valid && take_new) begin
      // [RQ4] capture only held data
      if (rpt.misc_ok) begin
        misc_reg <= rpt.misc;
      end
      if (rpt.addr_ok) begin
        addr_reg <= rpt.addr;
      end
    end
  end

  // ----------------------------------------
  // signalling
  // ----------------------------------------
  // [RQ3] route by class
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mce_reg <= 1'b0;
      cmc_reg <= 1'b0;
    end else begin
      mce_reg <= rpt.valid & n_mce;
      cmc_reg <= rpt.valid & ~n_mce;
    end
  end

  assign mce_out = mce_reg;
  assign cmc_out = cmc_reg;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= 32'h0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        err_bank_pkg::OFF_STATUS_LO: rdata_reg <= status_reg[31:0];
        err_bank_pkg::OFF_STATUS_HI: rdata_reg <= status_reg[63:32];
        err_bank_pkg::OFF_MISC_LO: rdata_reg <= misc_reg[31:0];
        err_bank_pkg::OFF_MISC_HI: rdata_reg <= misc_reg[63:32];
        err_bank_pkg::OFF_ADDR_LO: rdata_reg <= addr_reg[31:0];
        err_bank_pkg::OFF_ADDR_HI: rdata_reg <= addr_reg[63:32];
        err_bank_pkg::OFF_CAP: rdata_reg <= cap_word[31:0];
        default: rdata_reg <= 32'h0;
      endcase
    end else begin
      rdata_reg <= 32'h0;
    end
  end

  assign reg_rdata_out = rdata_reg;
endmodule

/* verification/err_bank_assertions.sv */
`timescale 1ns/10ps
module err_bank_assertions #(
  parameter bit SER_SUPPORTED = 1'b1
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic err_valid_in,
  input wire err_bank_pkg::err_class_t err_class_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic mce_out,
  input wire logic cmc_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // error in, signal one cycle later
  // ----------------------------------------
  // a same-cycle status write drops the error, so it is left out
  sequence s_err(err_bank_pkg::err_class_t c);
    err_valid_in && !reg_wr_in && err_class_in == c;
  endsequence
  sequence s_exc;
    mce_out && !cmc_out;
  endsequence
  property p_opt_exc;
    s_err(err_bank_pkg::ERR_OPT_ACTION) |=> s_exc;
  endproperty
  a_opt_exc: assert property (p_opt_exc) else $error("optional error gave no exception");
  property p_req_exc;
    s_err(err_bank_pkg::ERR_REQ_ACTION) |=> s_exc;
  endproperty
  a_req_exc: assert property (p_req_exc) else $error("required error gave no exception");
  property p_na_cmc;
    s_err(err_bank_pkg::ERR_NO_ACTION) |=> !SER_SUPPORTED || (cmc_out && !mce_out);
  endproperty
  a_na_cmc: assert property (p_na_cmc) else $error("no-action error not corrected");
  property p_fatal_exc;
    s_err(err_bank_pkg::ERR_FATAL) |=> s_exc;
  endproperty
  a_fatal_exc: assert property (p_fatal_exc) else $error("fatal error gave no exception");
  property p_corr_cmc;
    s_err(err_bank_pkg::ERR_CORRECTED) |=> cmc_out && !mce_out;
  endproperty
  a_corr_cmc: assert property (p_corr_cmc) else $error("corrected error misreported");
  property p_quiet;
    !err_valid_in |=> !mce_out && !cmc_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("signal without an error");
  property p_cap_bit;
    reg_rd_in && reg_addr_in == err_bank_pkg::OFF_CAP |=>
      reg_rdata_out[err_bank_pkg::CAP_SER_BIT] == SER_SUPPORTED;
  endproperty
  a_cap_bit: assert property (p_cap_bit) else $error("capability bit wrong");
  property p_rd_idle;
    !reg_rd_in |=> reg_rdata_out == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule
bind err_bank err_bank_assertions #(.SER_SUPPORTED(SER_SUPPORTED)) chk_u (
  .sys_clk_in(sys_clk_in),
  .rst_in(rst_in),
  .err_valid_in(err_valid_in),
  .err_class_in(err_class_in),
  .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .mce_out(mce_out),
  .cmc_out(cmc_out)
);

/* verification/err_source.sv */
`timescale 1ns/10ps
module err_source (
  input wire logic sys_clk_in,
  output logic valid_out,
  output err_bank_pkg::err_class_t class_out,
  output logic [15:0] code_out,
  output logic ok_out,
  output logic [63:0] data_out
);
  initial begin
    valid_out = 1'b0;
    class_out = err_bank_pkg::ERR_CORRECTED;
    code_out = 16'h0;
    ok_out = 1'b0;
    data_out = 64'h0;
  end
  // data with ok
  // qualifiers turn over after the strobe so stale values never match
  task automatic send(input err_bank_pkg::err_class_t c, input logic [15:0] k, input logic ok);
    @(posedge sys_clk_in);
    valid_out <= 1'b1;
    class_out <= c;
    code_out <= k;
    ok_out <= ok;
    data_out <= {48'h0, k};
    @(posedge sys_clk_in);
    valid_out <= 1'b0;
    code_out <= ~k;
    ok_out <= ~ok;
    data_out <= {48'hffffffffffff, ~k};
  endtask
endmodule

/* verification/err_bank_tb.sv */
`timescale 1ns/10ps
module err_bank_tb;
  localparam logic [7:0] BANKS = 8'h03;
  logic sys_clk_in, rst_in, err_valid, err_ok, reg_wr, reg_rd, machine_check_exception, cmc;
  err_bank_pkg::err_class_t err_class;
  logic [15:0] err_code;
  logic [63:0] err_data;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, rdata, d;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  err_source src (.sys_clk_in(sys_clk_in), .valid_out(err_valid), .class_out(err_class),
    .code_out(err_code), .ok_out(err_ok), .data_out(err_data));
  err_bank #(.BANK_COUNT(BANKS)) DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .err_valid_in(err_valid), .err_class_in(err_class), .err_code_in(err_code),
    .misc_ok_in(err_ok), .addr_ok_in(err_ok), .misc_data_in(err_data), .addr_data_in(err_data),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(rdata), .mce_out(machine_check_exception), .cmc_out(cmc));
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk_in);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // top status flags 63..55 expected after one or two errors
  function automatic logic [31:0] flags(input int a, input int b, input logic ov, input logic ok);
    logic uc;
    uc = (a != 0) || (b != 0);
    return {23'h0, 1'b1, ov, uc, uc, ok, ok, a == 4 || b == 4,
      a == 2 || a == 3 || b == 2 || b == 3, a == 3 || b == 3};
  endfunction
  task automatic t_single();
    for (int i = 0; i < 5; i++) begin
      src.send(err_bank_pkg::err_class_t'(i), 16'h0100 + 16'(i), i[0]);
      rd(4'h1, d);
      chk({23'h0, d[31:23]}, flags(i, i, 1'b0, i[0]));
      rd(4'h0, d);
      chk({16'h0, d[15:0]}, 32'h0100 + 32'(i));
      rd(4'h2, d);
      // without companion data the previous capture must stay untouched
      chk(d, i[0] ? 32'h0100 + 32'(i) : (i == 0 ? 32'h0 : 32'h00ff + 32'(i)));
      wr(4'h1, 32'h0);
      wr(4'h0, 32'h0);
      rd(4'h1, d);
      chk(d, 32'h0);
    end
  endtask
  task automatic t_merge();
    int a[7] = '{0, 1, 1, 3, 2, 4, 2};
    int b[7] = '{1, 0, 3, 1, 4, 2, 2};
    int ra, rb;
    for (int i = 0; i < 7; i++) begin
      src.send(err_bank_pkg::err_class_t'(a[i]), 16'h00a0, 1'b0);
      src.send(err_bank_pkg::err_class_t'(b[i]), 16'h00b0, 1'b0);
      ra = a[i] == 0 ? 0 : (a[i] == 4 ? 2 : 1);
      rb = b[i] == 0 ? 0 : (b[i] == 4 ? 2 : 1);
      rd(4'h1, d);
      chk({23'h0, d[31:23]}, flags(a[i], b[i], 1'b1, 1'b0));
      rd(4'h0, d);
      chk({16'h0, d[15:0]}, rb > ra ? 32'h00b0 : 32'h00a0);
      wr(4'h1, 32'h0);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    rst_in = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(err_bank_pkg::OFF_CAP, d);
    chk({23'h0, d[24], d[7:0]}, {23'h0, 1'b1, BANKS});
    rd(4'hf, d);
    chk(d, 32'h0);
    t_single();
    t_merge();
    test_done();
  end
endmodule
